// ==== verif/tb_prt_timer.sv ====
// Self-checking testbench for the ten-bit periodic timer
module tb_prt_timer;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals and instance
  // ****************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic timer_tick = 1'b0;
  logic timer_out;
  logic timer_out_en;
  logic match_a_flag;
  logic match_p_flag;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  int n;
  int hi;

  prt_timer DUT (
    .clk(clk),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .timer_tick(timer_tick),
    .timer_out(timer_out),
    .timer_out_en(timer_out_en),
    .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag)
  );

  // 125 MHz system clock
  always #4 clk = ~clk;

  // ****************************************
  // Closing report and comparison
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****************************************
  // Wishbone classic cycle
  // ****************************************
  // Ack is sampled before the edge's updates land, so the loop sees it at its own edge
  task automatic wb_cycle(input logic we, input logic [5:0] adr, input logic [7:0] d);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Stop, program, clear flags, then raise counter_on with the tick held off
  task automatic setup(input logic [1:0] md, input logic [1:0] pf, input logic ini,
                       input logic inv, input logic clr, input logic [9:0] a,
                       input logic [9:0] p);
    timer_tick <= 1'b0;
    wb_cycle(1'b1, prt_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wb_cycle(1'b1, prt_pkg::ADDR_TIMER_CONTROL_ONE, {md, pf, ini, inv, 1'b0, clr});
    wb_cycle(1'b1, prt_pkg::ADDR_COMPARE_A_LOW, a[7:0]);
    wb_cycle(1'b1, prt_pkg::ADDR_COMPARE_A_HIGH, {6'h00, a[9:8]});
    wb_cycle(1'b1, prt_pkg::ADDR_PERIOD_LOW, p[7:0]);
    wb_cycle(1'b1, prt_pkg::ADDR_PERIOD_HIGH, {6'h00, p[9:8]});
    wb_cycle(1'b1, prt_pkg::ADDR_FLAGS, 8'h03);
    wb_cycle(1'b1, prt_pkg::ADDR_CONTROL_ZERO, 8'h08);
    repeat (4) @(posedge clk);
  endtask

  // Counts high samples of the pin over fifty cycles, ten whole periods of five
  task automatic count_high();
    hi = 0;
    repeat (50)
    begin
      @(posedge clk);
      hi += int'(timer_out);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // Reset values of counter, compare and period bytes, plus an unmapped place
    for (int r = 2; r < 8; r++)
    begin
      wb_cycle(1'b0, 6'(r * 4), 8'h00);
      check(rd, 32'h00000000);
    end
    wb_cycle(1'b1, 6'h3c, 8'hff);
    wb_cycle(1'b0, 6'h3c, 8'h00);
    check(rd, 32'h00000000);
    // High bytes keep only two bits; counter bytes ignore writes
    wb_cycle(1'b1, prt_pkg::ADDR_COMPARE_A_HIGH, 8'hff);
    wb_cycle(1'b0, prt_pkg::ADDR_COMPARE_A_HIGH, 8'h00);
    check(rd, 32'h00000003);
    wb_cycle(1'b1, prt_pkg::ADDR_PERIOD_HIGH, 8'hfe);
    wb_cycle(1'b0, prt_pkg::ADDR_PERIOD_HIGH, 8'h00);
    check(rd, 32'h00000002);
    wb_cycle(1'b1, prt_pkg::ADDR_COUNTER_LOW, 8'h55);
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    check(rd, 32'h00000000);
    // Compare mode, period three: both flags, count never above three
    setup(2'b00, prt_pkg::PIN_TOGGLE, 1'b0, 1'b0, 1'b0, 10'h002, 10'h003);
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    check(rd, 32'h00000000);
    timer_tick <= 1'b1;
    repeat (6)
    begin
      wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
      check(32'(rd <= 32'h3), 32'h1);
    end
    wb_cycle(1'b0, prt_pkg::ADDR_FLAGS, 8'h00);
    check(rd, 32'h00000003);
    check(32'(timer_out_en), 32'h1);
    // Off and pause both keep the residual count
    wb_cycle(1'b1, prt_pkg::ADDR_CONTROL_ZERO, 8'h88);
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    rd2 = rd;
    // Six cycles of pause: a running count of period three would read differently
    repeat (3) @(posedge clk);
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    check(rd, rd2);
    wb_cycle(1'b1, prt_pkg::ADDR_CONTROL_ZERO, 8'h00);
    repeat (5) @(posedge clk);
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    check(rd, rd2);
    // Clear on comparator A: P flag stays low although period is below compare
    setup(2'b00, prt_pkg::PIN_NONE, 1'b0, 1'b0, 1'b1, 10'h003, 10'h001);
    timer_tick <= 1'b1;
    repeat (6)
    begin
      wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
      check(32'(rd <= 32'h3), 32'h1);
    end
    wb_cycle(1'b0, prt_pkg::ADDR_FLAGS, 8'h00);
    check(rd, 32'h00000001);
    // Every pin function; low is tried from a high start so a change shows
    for (int f = 0; f < 4; f++)
    begin
      setup(2'b00, 2'(f), f == 1, 1'b0, 1'b0, 10'h002, 10'h005);
      check(32'(timer_out), 32'(f == 1));
      timer_tick <= 1'b1;
      n = 0;
      while (match_a_flag !== 1'b1 && n < 50)
      begin
        @(posedge clk);
        n++;
      end
      timer_tick <= 1'b0;
      repeat (4) @(posedge clk);
      check(32'(n < 50), 32'h1);
      check(32'(timer_out), 32'(f >= 2));
    end
    // Period zero runs the full 1024 states before the P match
    setup(2'b00, prt_pkg::PIN_NONE, 1'b0, 1'b0, 1'b0, 10'h001, 10'h000);
    timer_tick <= 1'b1;
    n = 0;
    while (match_p_flag !== 1'b1 && n < 1100)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n >= 1020 && n <= 1030), 32'h1);
    // Timer mode: same flags, pin not driven
    setup(2'b11, prt_pkg::PIN_TOGGLE, 1'b1, 1'b0, 1'b0, 10'h002, 10'h003);
    // The count was left nonzero above, so this shows the counter-on rise zeroing it
    wb_cycle(1'b0, prt_pkg::ADDR_COUNTER_LOW, 8'h00);
    check(rd, 32'h00000000);
    timer_tick <= 1'b1;
    repeat (20) @(posedge clk);
    wb_cycle(1'b0, prt_pkg::ADDR_FLAGS, 8'h00);
    check(rd, 32'h00000003);
    check(32'(timer_out_en), 32'h0);
    // Capture code: counter runs on the period, only the P flag, pin released
    setup(2'b01, prt_pkg::PIN_NONE, 1'b0, 1'b0, 1'b0, 10'h002, 10'h003);
    timer_tick <= 1'b1;
    repeat (20) @(posedge clk);
    wb_cycle(1'b0, prt_pkg::ADDR_FLAGS, 8'h00);
    check(rd, 32'h00000002);
    check(32'(timer_out_en), 32'h0);
    // PWM with clear-select set: period four gives five states, two active
    setup(2'b10, prt_pkg::PIN_HIGH, 1'b1, 1'b0, 1'b1, 10'h002, 10'h004);
    timer_tick <= 1'b1;
    repeat (10) @(posedge clk);
    count_high();
    check(32'(hi), 32'd20);
    wb_cycle(1'b0, prt_pkg::ADDR_FLAGS, 8'h00);
    check(rd, 32'h00000003);
    // Duty at or above period, then inverted, then active low, then forced
    // Duty equal to period: the count reaches the duty value, yet duty stays full
    setup(2'b10, prt_pkg::PIN_HIGH, 1'b1, 1'b0, 1'b0, 10'h004, 10'h004);
    timer_tick <= 1'b1;
    count_high();
    check(32'(hi), 32'd50);
    setup(2'b10, prt_pkg::PIN_HIGH, 1'b1, 1'b1, 1'b0, 10'h006, 10'h004);
    timer_tick <= 1'b1;
    count_high();
    check(32'(hi), 32'd0);
    setup(2'b10, prt_pkg::PIN_HIGH, 1'b0, 1'b0, 1'b0, 10'h002, 10'h004);
    timer_tick <= 1'b1;
    repeat (10) @(posedge clk);
    count_high();
    check(32'(hi), 32'd30);
    setup(2'b10, prt_pkg::PIN_LOW, 1'b1, 1'b0, 1'b0, 10'h002, 10'h004);
    timer_tick <= 1'b1;
    count_high();
    check(32'(hi), 32'd50);
    setup(2'b10, prt_pkg::PIN_NONE, 1'b1, 1'b0, 1'b0, 10'h002, 10'h004);
    timer_tick <= 1'b1;
    count_high();
    check(32'(hi), 32'd0);
    complete_run();
  end

  // Run-length guard
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

endmodule

// ==== verilog/prt_pkg.sv ====
// Package holding register map, field layout and mode codes of the periodic timer
package prt_pkg;

  // ****************************************
  // Register word offsets (byte addresses)
  // ****************************************
  localparam logic [5:0] ADDR_CONTROL_ZERO = 6'h00;
  localparam logic [5:0] ADDR_TIMER_CONTROL_ONE = 6'h04;
  localparam logic [5:0] ADDR_COUNTER_LOW = 6'h08;
  localparam logic [5:0] ADDR_COUNTER_HIGH = 6'h0c;
  localparam logic [5:0] ADDR_COMPARE_A_LOW = 6'h10;
  localparam logic [5:0] ADDR_COMPARE_A_HIGH = 6'h14;
  localparam logic [5:0] ADDR_PERIOD_LOW = 6'h18;
  localparam logic [5:0] ADDR_PERIOD_HIGH = 6'h1c;
  localparam logic [5:0] ADDR_FLAGS = 6'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_PAUSE = 7;
  localparam int BIT_COUNTER_ON = 3;
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_PIN_FUNCTION_HI = 5;
  localparam int BIT_PIN_FUNCTION_LO = 4;
  localparam int BIT_INITIAL_LEVEL = 3;
  localparam int BIT_INVERT = 2;
  localparam int BIT_CLEAR_SELECT = 0;
  localparam int BIT_FLAG_A = 0;
  localparam int BIT_FLAG_P = 1;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int COUNT_W = 10;
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Operating modes
  typedef enum logic [1:0] {
    PRT_MODE_COMPARE = 2'b00,
    PRT_MODE_CAPTURE = 2'b01,
    PRT_MODE_PWM = 2'b10,
    PRT_MODE_TIMER = 2'b11
  } prt_mode_t;

  // Pin function codes
  localparam logic [1:0] PIN_NONE = 2'b00;
  localparam logic [1:0] PIN_LOW = 2'b01;
  localparam logic [1:0] PIN_HIGH = 2'b10;
  localparam logic [1:0] PIN_TOGGLE = 2'b11;

endpackage

// ==== verilog/prt_timer.sv ====
// Ten-bit periodic timer with compare, timer and PWM modes behind a Wishbone slave
module prt_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer clock enable from the unit prescaler, same clock domain
  input wire logic timer_tick,
  // Output pin and status
  output logic timer_out,
  output logic timer_out_en,
  output logic match_a_flag,
  output logic match_p_flag
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] control_zero;
  logic [7:0] timer_control_one;
  logic [9:0] compare_a_value;
  logic [9:0] period_value;
  logic [9:0] count;
  logic on_prev;
  logic cmp_level;

  // Field views
  prt_pkg::prt_mode_t mode;
  logic [1:0] pin_function;
  logic counter_on;
  logic pause;
  logic clear_select;
  logic output_initial_level;
  logic output_invert;

  assign mode = prt_pkg::prt_mode_t'({timer_control_one[prt_pkg::BIT_MODE_HI],
                             timer_control_one[prt_pkg::BIT_MODE_LO]});
  assign pin_function = {timer_control_one[prt_pkg::BIT_PIN_FUNCTION_HI],
                         timer_control_one[prt_pkg::BIT_PIN_FUNCTION_LO]};
  assign counter_on = control_zero[prt_pkg::BIT_COUNTER_ON];
  assign pause = control_zero[prt_pkg::BIT_PAUSE];
  assign clear_select = timer_control_one[prt_pkg::BIT_CLEAR_SELECT];
  assign output_initial_level = timer_control_one[prt_pkg::BIT_INITIAL_LEVEL];
  assign output_invert = timer_control_one[prt_pkg::BIT_INVERT];

  // ****************************************
  // Bus decode
  // ****************************************
  logic bus_req;
  logic wr_lane;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_p_lo;
  logic wr_p_hi;
  logic wr_flags;

  // Writes land on the edge at which the master samples ack, byte lane zero only
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_lane = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_ctl0 = wr_lane & (wb_adr_i == prt_pkg::ADDR_CONTROL_ZERO);
  assign wr_ctl1 = wr_lane & (wb_adr_i == prt_pkg::ADDR_TIMER_CONTROL_ONE);
  assign wr_a_lo = wr_lane & (wb_adr_i == prt_pkg::ADDR_COMPARE_A_LOW);
  assign wr_a_hi = wr_lane & (wb_adr_i == prt_pkg::ADDR_COMPARE_A_HIGH);
  assign wr_p_lo = wr_lane & (wb_adr_i == prt_pkg::ADDR_PERIOD_LOW);
  assign wr_p_hi = wr_lane & (wb_adr_i == prt_pkg::ADDR_PERIOD_HIGH);
  assign wr_flags = wr_lane & (wb_adr_i == prt_pkg::ADDR_FLAGS);

  // Ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req & ~wb_ack_o;
  end

  // Read mux; unmapped addresses and unused bits read zero
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == prt_pkg::ADDR_CONTROL_ZERO)
      next_rdata[7:0] = control_zero;
    else if (wb_adr_i == prt_pkg::ADDR_TIMER_CONTROL_ONE)
      next_rdata[7:0] = timer_control_one;
    else if (wb_adr_i == prt_pkg::ADDR_COUNTER_LOW)
      next_rdata[7:0] = count[7:0];
    else if (wb_adr_i == prt_pkg::ADDR_COUNTER_HIGH)
      next_rdata[1:0] = count[9:8];
    else if (wb_adr_i == prt_pkg::ADDR_COMPARE_A_LOW)
      next_rdata[7:0] = compare_a_value[7:0];
    else if (wb_adr_i == prt_pkg::ADDR_COMPARE_A_HIGH)
      next_rdata[1:0] = compare_a_value[9:8];
    else if (wb_adr_i == prt_pkg::ADDR_PERIOD_LOW)
      next_rdata[7:0] = period_value[7:0];
    else if (wb_adr_i == prt_pkg::ADDR_PERIOD_HIGH)
      next_rdata[1:0] = period_value[9:8];
    else if (wb_adr_i == prt_pkg::ADDR_FLAGS)
    begin
      next_rdata[prt_pkg::BIT_FLAG_A] = match_a_flag;
      next_rdata[prt_pkg::BIT_FLAG_P] = match_p_flag;
    end
  end

  // Read data captured with the ack so it is stable while ack is high
  always_ff @(posedge clk)
  begin
    if (srst)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req & ~wb_ack_o)
      wb_dat_o <= next_rdata;
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Control bytes; unused control-zero bits stay zero
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      control_zero <= prt_pkg::CONTROL_RESET;
      timer_control_one <= prt_pkg::CONTROL_RESET;
    end
    else
    begin
      if (wr_ctl0)
        control_zero <= wb_dat_i[7:0] & 8'h88;
      if (wr_ctl1)
        timer_control_one <= wb_dat_i[7:0];
    end
  end

  // Compare values; only two bits of each high byte exist
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      compare_a_value <= prt_pkg::COUNT_RESET;
      period_value <= prt_pkg::COUNT_RESET;
    end
    else
    begin
      if (wr_a_lo)
        compare_a_value[7:0] <= wb_dat_i[7:0];
      if (wr_a_hi)
        compare_a_value[9:8] <= wb_dat_i[1:0];
      if (wr_p_lo)
        period_value[7:0] <= wb_dat_i[7:0];
      if (wr_p_hi)
        period_value[9:8] <= wb_dat_i[1:0];
    end
  end

  // ****************************************
  // Counter and comparators
  // ****************************************
  logic on_rise;
  logic run_tick;
  logic a_hit;
  logic p_hit;
  logic clr_hit;
  logic a_set;
  logic p_set;
  logic cmp_like;

  assign on_rise = counter_on & ~on_prev;
  assign run_tick = counter_on & ~pause & timer_tick;
  assign cmp_like = (mode == prt_pkg::PRT_MODE_COMPARE) | (mode == prt_pkg::PRT_MODE_TIMER);
  // Equality compare; a zero period stands for a full 1024-count cycle
  assign a_hit = run_tick & (count == compare_a_value);
  assign p_hit = run_tick & ((period_value == prt_pkg::COUNT_RESET) ?
                             (count == prt_pkg::COUNT_MAX) :
                             (count == period_value));

  // Clear source depends on mode; PWM and capture ignore clear-select
  always_comb
  begin
    clr_hit = p_hit;
    case (mode)
      prt_pkg::PRT_MODE_COMPARE: clr_hit = clear_select ? a_hit : p_hit;
      prt_pkg::PRT_MODE_TIMER: clr_hit = clear_select ? a_hit : p_hit;
      prt_pkg::PRT_MODE_PWM: clr_hit = p_hit;
      default: clr_hit = p_hit;
    endcase
  end

  // Capture itself is not built, so comparator A raises nothing there
  assign a_set = a_hit & (mode != prt_pkg::PRT_MODE_CAPTURE);
  assign p_set = p_hit & ~(cmp_like & clear_select);

  // Counter-on edge detector; the control bit is same-domain logic
  always_ff @(posedge clk)
  begin
    if (srst)
      on_prev <= 1'b0;
    else
      on_prev <= counter_on;
  end

  // Count: zeroed on enable rise, held when off or paused
  always_ff @(posedge clk)
  begin
    if (srst)
      count <= prt_pkg::COUNT_RESET;
    else if (on_rise)
      count <= prt_pkg::COUNT_RESET;
    else if (run_tick)
    begin
      if (clr_hit)
        count <= prt_pkg::COUNT_RESET;
      else
        count <= count + 10'h001;
    end
  end

  // Sticky flags; write one clears, a same-cycle set wins over the clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end
    else
    begin
      match_a_flag <= a_set | (match_a_flag & ~(wr_flags & wb_dat_i[prt_pkg::BIT_FLAG_A]));
      match_p_flag <= p_set | (match_p_flag & ~(wr_flags & wb_dat_i[prt_pkg::BIT_FLAG_P]));
    end
  end

  // ****************************************
  // Output pin
  // ****************************************
  // Compare-mode pin state; loaded with the initial level on counter-on rise, then only an A match moves it, P matches never do
  always_ff @(posedge clk)
  begin
    if (srst)
      cmp_level <= 1'b0;
    else if (on_rise)
      cmp_level <= output_initial_level;
    else if (a_set & (mode == prt_pkg::PRT_MODE_COMPARE))
    begin
      case (pin_function)
        prt_pkg::PIN_LOW: cmp_level <= 1'b0;
        prt_pkg::PIN_HIGH: cmp_level <= 1'b1;
        prt_pkg::PIN_TOGGLE: cmp_level <= ~cmp_level;
        default: cmp_level <= cmp_level;
      endcase
    end
  end

  // PWM waveform: active while count is below duty, full duty at or above period
  logic pwm_active;
  logic pwm_level;
  assign pwm_active = ((period_value != prt_pkg::COUNT_RESET) &&
                       (compare_a_value >= period_value)) ? 1'b1 :
                      (count < compare_a_value);
  // Single pulse is not built; code 11 parks the pin inactive
  always_comb
  begin
    case (pin_function)
      prt_pkg::PIN_NONE: pwm_level = ~output_initial_level;
      prt_pkg::PIN_LOW: pwm_level = output_initial_level;
      prt_pkg::PIN_HIGH: pwm_level = pwm_active ? output_initial_level : ~output_initial_level;
      default: pwm_level = ~output_initial_level;
    endcase
  end

  // Registered pin; timer and capture modes release it for other use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end
    else
    begin
      case (mode)
        prt_pkg::PRT_MODE_COMPARE:
        begin
          timer_out <= cmp_level ^ output_invert;
          timer_out_en <= 1'b1;
        end
        prt_pkg::PRT_MODE_PWM:
        begin
          timer_out <= pwm_level ^ output_invert;
          timer_out_en <= 1'b1;
        end
        default:
        begin
          timer_out <= 1'b0;
          timer_out_en <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_rise_zeroes: assert property (
    @(posedge clk) disable iff (srst) on_rise |=> (count == 10'h000))
    else $error("Count not zero after counter-on rise");

  a_off_holds: assert property (
    @(posedge clk) disable iff (srst) (!counter_on && !on_rise) |=> $stable(count))
    else $error("Count moved while counter off");

  a_count_steps: assert property (
    @(posedge clk) disable iff (srst)
    (run_tick && !clr_hit && !on_rise) |=> (count == $past(count) + 10'h001))
    else $error("Count did not advance by one on tick");

  a_high_zero: assert property (
    @(posedge clk) disable iff (srst)
    (wb_ack_o && !wb_we_i && (wb_adr_i == prt_pkg::ADDR_COUNTER_HIGH ||
     wb_adr_i == prt_pkg::ADDR_COMPARE_A_HIGH || wb_adr_i == prt_pkg::ADDR_PERIOD_HIGH))
    |-> (wb_dat_o[31:2] == 30'h0))
    else $error("High byte unused bits not zero");

  a_p_clears: assert property (
    @(posedge clk) disable iff (srst)
    (mode == prt_pkg::PRT_MODE_COMPARE && !clear_select && p_hit && !on_rise)
    |=> (count == 10'h000) && match_p_flag)
    else $error("Period match did not clear counter and set flag");

  a_no_p_flag: assert property (
    @(posedge clk) disable iff (srst)
    (cmp_like && clear_select && !match_p_flag) |=> !match_p_flag)
    else $error("P flag raised with clear-select high");

  a_pin_a_only: assert property (
    @(posedge clk) disable iff (srst)
    (mode == prt_pkg::PRT_MODE_COMPARE && !a_set && !on_rise) |=> $stable(cmp_level))
    else $error("Pin state moved without an A match");

  a_init_level: assert property (
    @(posedge clk) disable iff (srst)
    (on_rise && mode == prt_pkg::PRT_MODE_COMPARE && $stable(timer_control_one))
    |=> ##1 (timer_out == (output_initial_level ^ output_invert)))
    else $error("Pin not at initial level after counter-on rise");

  a_pwm_full: assert property (
    @(posedge clk) disable iff (srst)
    (mode == prt_pkg::PRT_MODE_PWM && pin_function == prt_pkg::PIN_HIGH &&
     period_value != 10'h000 && compare_a_value >= period_value)
    |=> (timer_out == ($past(output_initial_level) ^ $past(output_invert))))
    else $error("PWM not at full duty");

  a_timer_free: assert property (
    @(posedge clk) disable iff (srst) (mode == prt_pkg::PRT_MODE_TIMER) |=> !timer_out_en)
    else $error("Pin driven in timer mode");

  c_pwm_period: cover property (
    @(posedge clk) disable iff (srst) (mode == prt_pkg::PRT_MODE_PWM) && p_hit);
  c_cmp_toggle: cover property (
    @(posedge clk) disable iff (srst)
    (mode == prt_pkg::PRT_MODE_COMPARE) && a_set && (pin_function == prt_pkg::PIN_TOGGLE));
  c_flag_clear: cover property (
    @(posedge clk) disable iff (srst) match_a_flag && wr_flags ##1 !match_a_flag);

endmodule
